// ===== core/boundary_scan_tap.v
// Function
// - instruction bits shift into a stage, then load in parallel on update
// - four-bit instruction; 1111 bypass, 0000 extest, 0100 sample/preload
// - 1101 idcode, 0111 internal scan mode, 0101 high-impedance
// - tdi is sampled at each rising tck edge
// - an unterminated tdi reads as high
// - an undriven tms reads as high
// - tdo is enabled by the tap only while shifting
// - trst low forces test-logic-reset without a tck edge
// - state advances only on rising tck, chosen by sampled tms
// - capture, shift and update act on the rising edge after entry
// - bypass links tdi to tdo through one stage
// - boundary cells form one serial path from tdi to tdo
// - input pin cell is one stage that samples and shifts
// - output pin cell has two stages and an output multiplexer
// - bidirectional cell captures the incoming pin and holds the output
// - trst resets instruction latches and the state machine
// - test reset loads the idcode instruction 1101
// - in test-logic-reset functional pins carry normal operation
// - leaving test-logic-reset needs a tms sequence clocked by tck
// - ten tms-high tck cycles always reach test-logic-reset
`timescale 1ns/1ns
`default_nettype none
`include "tap_consts.vh"

module boundary_scan_tap #(
  parameter N_IN = 4,
  parameter N_OUT = 4,
  parameter N_BD = 4,
  parameter [`TAP_ID_W-1:0] ID_CODE = `TAP_ID_DEFAULT // arbitrary value
) (
  // clock and reset
  input wire i_clk,
  input wire i_srst,
  // test port pins, with flags that mark an undriven pin
  input wire i_tck,
  input wire i_tms,
  input wire i_tms_float,
  input wire i_tdi,
  input wire i_tdi_float,
  input wire i_trst_n,
  input wire i_trst_float,
  output reg o_tdo,
  output reg o_tdo_oe,
  // input-only pins
  input wire [N_IN-1:0] i_pin_in,
  output reg [N_IN-1:0] o_core_in,
  // output-only pins
  input wire [N_OUT-1:0] i_core_out,
  output reg [N_OUT-1:0] o_pin_out,
  output reg [N_OUT-1:0] o_pin_out_oe,
  // bidirectional pins
  input wire [N_BD-1:0] i_core_bd_out,
  input wire [N_BD-1:0] i_core_bd_oe,
  input wire [N_BD-1:0] i_pin_bd_in,
  output reg [N_BD-1:0] o_pin_bd_out,
  output reg [N_BD-1:0] o_pin_bd_oe,
  output reg [N_BD-1:0] o_core_bd_in,
  // mode flags
  output reg o_scan_mode,
  output reg o_test_reset
);

  localparam N_TOT = N_IN + N_OUT + N_BD;
  localparam NS = 6;

  localparam [3:0] ST_TLR = 4'h0;
  localparam [3:0] ST_RTI = 4'h1;
  localparam [3:0] ST_SEL_DR = 4'h2;
  localparam [3:0] ST_CAP_DR = 4'h3;
  localparam [3:0] ST_SH_DR = 4'h4;
  localparam [3:0] ST_EX1_DR = 4'h5;
  localparam [3:0] ST_PA_DR = 4'h6;
  localparam [3:0] ST_EX2_DR = 4'h7;
  localparam [3:0] ST_UPD_DR = 4'h8;
  localparam [3:0] ST_SEL_IR = 4'h9;
  localparam [3:0] ST_CAP_IR = 4'hA;
  localparam [3:0] ST_SH_IR = 4'hB;
  localparam [3:0] ST_EX1_IR = 4'hC;
  localparam [3:0] ST_PA_IR = 4'hD;
  localparam [3:0] ST_EX2_IR = 4'hE;
  localparam [3:0] ST_UPD_IR = 4'hF;

  // next tap state from current state and sampled tms
  function [3:0] next_state;
    input [3:0] st;
    input tms;
    begin
      case (st)
        ST_TLR: next_state = tms ? ST_TLR : ST_RTI;
        ST_RTI: next_state = tms ? ST_SEL_DR : ST_RTI;
        ST_SEL_DR: next_state = tms ? ST_SEL_IR : ST_CAP_DR;
        ST_CAP_DR: next_state = tms ? ST_EX1_DR : ST_SH_DR;
        ST_SH_DR: next_state = tms ? ST_EX1_DR : ST_SH_DR;
        ST_EX1_DR: next_state = tms ? ST_UPD_DR : ST_PA_DR;
        ST_PA_DR: next_state = tms ? ST_EX2_DR : ST_PA_DR;
        ST_EX2_DR: next_state = tms ? ST_UPD_DR : ST_SH_DR;
        ST_UPD_DR: next_state = tms ? ST_SEL_DR : ST_RTI;
        ST_SEL_IR: next_state = tms ? ST_TLR : ST_CAP_IR;
        ST_CAP_IR: next_state = tms ? ST_EX1_IR : ST_SH_IR;
        ST_SH_IR: next_state = tms ? ST_EX1_IR : ST_SH_IR;
        ST_EX1_IR: next_state = tms ? ST_UPD_IR : ST_PA_IR;
        ST_PA_IR: next_state = tms ? ST_EX2_IR : ST_PA_IR;
        ST_EX2_IR: next_state = tms ? ST_UPD_IR : ST_SH_IR;
        ST_UPD_IR: next_state = tms ? ST_SEL_DR : ST_RTI;
        default: next_state = ST_TLR;
      endcase
    end
  endfunction

  // data register chosen by an instruction; unknown codes take bypass
  function [1:0] dr_select;
    input [`TAP_IR_W-1:0] op;
    begin
      case (op)
        `TAP_OP_EXTEST: dr_select = `TAP_DR_BSR;
        `TAP_OP_SAMPLE: dr_select = `TAP_DR_BSR;
        `TAP_OP_IDCODE: dr_select = `TAP_DR_ID;
        `TAP_OP_HIGHZ: dr_select = `TAP_DR_BYPASS;
        `TAP_OP_SCAN: dr_select = `TAP_DR_BYPASS;
        `TAP_OP_BYPASS: dr_select = `TAP_DR_BYPASS;
        default: dr_select = `TAP_DR_BYPASS;
      endcase
    end
  endfunction

  // pin synchronisers
  wire [NS-1:0] pins_s;
  wire [N_IN-1:0] pin_in_s;
  wire [N_BD-1:0] pin_bd_s;

  pin_sync #(.W(NS)) u_sync_tap (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_async({i_tck, i_tms, i_tms_float, i_tdi, i_tdi_float, ~i_trst_float & ~i_trst_n}),
    .o_sync(pins_s)
  );

  pin_sync #(.W(N_IN + N_BD)) u_sync_pins (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_async({i_pin_bd_in, i_pin_in}),
    .o_sync({pin_bd_s, pin_in_s})
  );

  wire tck_s = pins_s[5];
  wire tms_eff = pins_s[4] | pins_s[3];
  wire tdi_eff = pins_s[2] | pins_s[1];
  wire trst_act = pins_s[0];

  reg tck_d_r;
  reg [3:0] state_r;
  reg [`TAP_IR_W-1:0] ir_sh_r;
  reg [`TAP_IR_W-1:0] ir_r;
  reg byp_r;
  reg [`TAP_ID_W-1:0] id_r;

  wire tck_rise = tck_s & ~tck_d_r;
  wire tck_fall = ~tck_s & tck_d_r;
  wire tap_rst = trst_act;
  wire [1:0] dr_sel = dr_select(ir_r);
  wire cap_dr = tck_rise && (state_r == ST_CAP_DR);
  wire sh_dr = tck_rise && (state_r == ST_SH_DR);
  wire upd_dr = tck_rise && (state_r == ST_UPD_DR);
  wire bsr_sel = (dr_sel == `TAP_DR_BSR);

  always @(posedge i_clk) begin
    if (i_srst) begin
      tck_d_r <= 1'b0;
    end else begin
      tck_d_r <= tck_s;
    end
  end

  // tap state machine
  always @(posedge i_clk) begin
    if (i_srst || tap_rst) begin
      state_r <= ST_TLR;
    end else if (tck_rise) begin
      state_r <= next_state(state_r, tms_eff);
    end
  end

  // instruction register: shift stage then parallel latches
  always @(posedge i_clk) begin
    if (i_srst || tap_rst) begin
      ir_sh_r <= `TAP_IR_CAPTURE;
      ir_r <= `TAP_IR_RESET;
    end else if (tck_rise) begin
      case (state_r)
        ST_TLR: ir_r <= `TAP_IR_RESET;
        ST_CAP_IR: ir_sh_r <= `TAP_IR_CAPTURE;
        ST_SH_IR: ir_sh_r <= {tdi_eff, ir_sh_r[`TAP_IR_W-1:1]};
        ST_UPD_IR: ir_r <= ir_sh_r;
        default: ir_r <= ir_r;
      endcase
    end
  end

  // bypass and identification registers
  always @(posedge i_clk) begin
    if (i_srst || tap_rst) begin
      byp_r <= 1'b0;
      id_r <= {`TAP_ID_W{1'b0}};
    end else begin
      if (cap_dr && dr_sel == `TAP_DR_BYPASS) begin
        byp_r <= 1'b0;
      end else if (sh_dr && dr_sel == `TAP_DR_BYPASS) begin
        byp_r <= tdi_eff;
      end
      if (cap_dr && dr_sel == `TAP_DR_ID) begin
        id_r <= {ID_CODE[`TAP_ID_W-1:1], 1'b1};
      end else if (sh_dr && dr_sel == `TAP_DR_ID) begin
        id_r <= {tdi_eff, id_r[`TAP_ID_W-1:1]};
      end
    end
  end

  // boundary-scan chain, bit 0 nearest tdo
  wire [N_TOT:0] chain;
  wire [N_TOT-1:0] cap_vec = {pin_bd_s, i_core_out, pin_in_s};
  wire [N_TOT-1:0] upd_vec;
  assign chain[N_TOT] = tdi_eff;

  genvar gi;
  generate
    for (gi = 0; gi < N_TOT; gi = gi + 1) begin : g_cell
      bsr_cell #(
        .KIND(gi < N_IN ? `BSR_KIND_IN :
              (gi < N_IN + N_OUT ? `BSR_KIND_OUT : `BSR_KIND_BIDIR))
      ) u_cell (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_rst_tap(tap_rst),
        .i_capture(cap_dr && bsr_sel),
        .i_shift(sh_dr && bsr_sel),
        .i_update(upd_dr && bsr_sel),
        .i_si(chain[gi+1]),
        .i_cap_val(cap_vec[gi]),
        .o_so(chain[gi]),
        .o_upd(upd_vec[gi])
      );
    end
  endgenerate

  // serial output selection
  reg tdo_nxt;
  always @* begin
    tdo_nxt = byp_r;
    if (state_r == ST_SH_IR) begin
      tdo_nxt = ir_sh_r[0];
    end else if (dr_sel == `TAP_DR_ID) begin
      tdo_nxt = id_r[0];
    end else if (dr_sel == `TAP_DR_BSR) begin
      tdo_nxt = chain[0];
    end
  end

  // tdo changes on the falling tck edge, enabled only while shifting
  always @(posedge i_clk) begin
    if (i_srst || tap_rst) begin
      o_tdo <= 1'b0;
      o_tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      o_tdo <= tdo_nxt;
      o_tdo_oe <= (state_r == ST_SH_DR) || (state_r == ST_SH_IR);
    end
  end

  // functional pin multiplexers
  wire in_tlr = (state_r == ST_TLR);
  wire extest_on = !in_tlr && (ir_r == `TAP_OP_EXTEST);
  wire highz_on = !in_tlr && (ir_r == `TAP_OP_HIGHZ);

  always @(posedge i_clk) begin
    if (i_srst) begin
      o_core_in <= {N_IN{1'b0}};
      o_pin_out <= {N_OUT{1'b0}};
      o_pin_out_oe <= {N_OUT{1'b0}};
      o_pin_bd_out <= {N_BD{1'b0}};
      o_pin_bd_oe <= {N_BD{1'b0}};
      o_core_bd_in <= {N_BD{1'b0}};
      o_scan_mode <= 1'b0;
      o_test_reset <= 1'b1;
    end else begin
      o_core_in <= pin_in_s;
      o_core_bd_in <= pin_bd_s;
      o_scan_mode <= !in_tlr && (ir_r == `TAP_OP_SCAN);
      o_test_reset <= in_tlr;
      if (highz_on) begin
        o_pin_out <= i_core_out;
        o_pin_out_oe <= {N_OUT{1'b0}};
        o_pin_bd_out <= i_core_bd_out;
        o_pin_bd_oe <= {N_BD{1'b0}};
      end else if (extest_on) begin
        o_pin_out <= upd_vec[N_IN +: N_OUT];
        o_pin_out_oe <= {N_OUT{1'b1}};
        o_pin_bd_out <= upd_vec[N_IN + N_OUT +: N_BD];
        o_pin_bd_oe <= i_core_bd_oe;
      end else begin
        o_pin_out <= i_core_out;
        o_pin_out_oe <= {N_OUT{1'b1}};
        o_pin_bd_out <= i_core_bd_out;
        o_pin_bd_oe <= i_core_bd_oe;
      end
    end
  end

endmodule

`default_nettype wire

// ===== core/tap_consts.vh
`ifndef TAP_CONSTS_VH
`define TAP_CONSTS_VH

// instruction register
`define TAP_IR_W 4
`define TAP_OP_EXTEST 4'h0
`define TAP_OP_SAMPLE 4'h4
`define TAP_OP_HIGHZ 4'h5
`define TAP_OP_SCAN 4'h7
`define TAP_OP_IDCODE 4'hD
`define TAP_OP_BYPASS 4'hF
`define TAP_IR_RESET `TAP_OP_IDCODE
`define TAP_IR_CAPTURE 4'h1

// identification register
`define TAP_ID_W 32
`define TAP_ID_DEFAULT 32'h0A5C_3E01

// data register selections
`define TAP_DR_BYPASS 2'h0
`define TAP_DR_BSR 2'h1
`define TAP_DR_ID 2'h2

// boundary cell kinds
`define BSR_KIND_IN 0
`define BSR_KIND_OUT 1
`define BSR_KIND_BIDIR 2

// tms-high cycles that always reach test-logic-reset
`define TAP_TMS_RESET_CYCLES 10

`endif

// ===== core/pin_sync.v
`timescale 1ns/1ns
`default_nettype none

module pin_sync #(
  parameter W = 1
) (
  // clock and reset
  input wire i_clk,
  input wire i_srst,
  // asynchronous inputs and their synchronised copies
  input wire [W-1:0] i_async,
  output wire [W-1:0] o_sync
);

  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;

  // two-stage synchroniser, first stage read only by the second
  always @(posedge i_clk) begin
    if (i_srst) begin
      meta_r <= {W{1'b0}};
      sync_r <= {W{1'b0}};
    end else begin
      meta_r <= i_async;
      sync_r <= meta_r;
    end
  end

  assign o_sync = sync_r;

endmodule

`default_nettype wire

// ===== core/bsr_cell.v
`timescale 1ns/1ns
`default_nettype none

module bsr_cell #(
  parameter KIND = 0
) (
  // clock and resets
  input wire i_clk,
  input wire i_srst,
  input wire i_rst_tap,
  // controls from the tap, one-cycle strobes
  input wire i_capture,
  input wire i_shift,
  input wire i_update,
  // serial chain and captured value
  input wire i_si,
  input wire i_cap_val,
  output wire o_so,
  output wire o_upd
);

  reg shift_r;
  reg upd_r;

  // shift stage: sample and shift
  always @(posedge i_clk) begin
    if (i_srst || i_rst_tap) begin
      shift_r <= 1'b0;
    end else if (i_capture) begin
      shift_r <= i_cap_val;
    end else if (i_shift) begin
      shift_r <= i_si;
    end
  end

  // second stage holds the test value driven on output pins
  generate
    if (KIND == 0) begin : g_in
      always @(posedge i_clk) begin
        upd_r <= 1'b0;
      end
    end else begin : g_out
      always @(posedge i_clk) begin
        if (i_srst || i_rst_tap) begin
          upd_r <= 1'b0;
        end else if (i_update) begin
          upd_r <= shift_r;
        end
      end
    end
  endgenerate

  assign o_so = shift_r;
  assign o_upd = upd_r;

endmodule

`default_nettype wire

// ===== bench/tap_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module tap_asserts #(
  parameter N_OUT = 4,
  parameter N_BD = 4
) (
  // clock and test pins
  input wire i_clk,
  input wire i_srst,
  input wire i_tck,
  input wire i_tms,
  input wire i_tms_float,
  input wire i_trst_n,
  input wire i_trst_float,
  input wire o_tdo,
  input wire o_tdo_oe,
  // functional pins and flags
  input wire [N_OUT-1:0] i_core_out,
  input wire [N_OUT-1:0] o_pin_out,
  input wire [N_BD-1:0] i_core_bd_out,
  input wire [N_BD-1:0] i_core_bd_oe,
  input wire [N_BD-1:0] o_pin_bd_out,
  input wire [N_BD-1:0] o_pin_bd_oe,
  input wire o_scan_mode,
  input wire o_test_reset
);
  reg tck_d_r;
  reg [3:0] hi_cnt_r;
  wire trst_on = !i_trst_n && !i_trst_float;
  wire hi5 = hi_cnt_r > 4'h4;
  // counts tck rises seen with tms high, saturating at ten
  always @(posedge i_clk) begin
    tck_d_r <= i_tck;
    if (i_srst || trst_on) hi_cnt_r <= 4'h0;
    else if (i_tck && !tck_d_r) begin
      if (i_tms || i_tms_float) hi_cnt_r <= hi_cnt_r + {3'h0, hi_cnt_r != 4'hA};
      else hi_cnt_r <= 4'h0;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  oe_idle_a: assert property (o_test_reset && $past(o_test_reset, 2) |-> !o_tdo_oe)
    else $error("tdo enabled in reset state");
  tdo_edge_a: assert property ($changed(o_tdo) || $changed(o_tdo_oe) |->
    $past(!i_tck, 2) || trst_on) else $error("tdo moved off a tck fall");
  state_edge_a: assert property ($changed(o_test_reset) |-> $past(i_tck, 2) || trst_on)
    else $error("reset state moved without tck rise");
  // the first cycle after i_srst still shows the cleared pin registers
  pins_follow_a: assert property (o_test_reset && $past(o_test_reset, 2) && !$past(i_srst) |->
    o_pin_out == $past(i_core_out)) else $error("output pins not from core");
  bd_follow_a: assert property (o_test_reset && $past(o_test_reset, 2) && !$past(i_srst) |->
    {o_pin_bd_out, o_pin_bd_oe} == $past({i_core_bd_out, i_core_bd_oe}))
    else $error("bidir pins not from core");
  trst_reset_a: assert property (trst_on [*2] |-> ##[0:3] o_test_reset)
    else $error("trst did not reset");
  trst_oe_a: assert property (trst_on [*5] |-> !o_tdo_oe && !o_tdo)
    else $error("trst left tdo active");
  scan_tlr_a: assert property (o_test_reset [*2] |-> !o_scan_mode)
    else $error("scan mode in reset state");
  tms_reset_a: assert property (hi5 && $past(hi5, 6) |-> o_test_reset)
    else $error("tms high did not reset");
  cover property ($rose(o_tdo_oe));
  cover property ($rose(o_scan_mode));
  cover property ($fell(o_test_reset));
endmodule
bind boundary_scan_tap tap_asserts #(.N_OUT(N_OUT), .N_BD(N_BD)) chk_i (
  .i_clk(i_clk), .i_srst(i_srst), .i_tck(i_tck), .i_tms(i_tms), .i_tms_float(i_tms_float),
  .i_trst_n(i_trst_n), .i_trst_float(i_trst_float), .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe),
  .i_core_out(i_core_out), .o_pin_out(o_pin_out), .i_core_bd_out(i_core_bd_out),
  .i_core_bd_oe(i_core_bd_oe), .o_pin_bd_out(o_pin_bd_out), .o_pin_bd_oe(o_pin_bd_oe),
  .o_scan_mode(o_scan_mode), .o_test_reset(o_test_reset));
`default_nettype wire

// ===== bench/tap_tester.sv
`timescale 1ns/1ns
`default_nettype none
module tap_tester (
  // clock and returned data
  input wire i_clk,
  input wire i_tdo,
  // test pins
  output logic o_tck,
  output logic o_tms,
  output logic o_tdi
);
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b1;
  end
  // one tck period; tdo is read late in the high half
  task automatic bit_io(input logic tms, input logic tdi, output logic tdo);
    @(negedge i_clk);
    o_tck = 1'b0;
    o_tms = tms;
    o_tdi = tdi;
    repeat (4) @(negedge i_clk);
    o_tck = 1'b1;
    repeat (3) @(negedge i_clk);
    tdo = i_tdo;
  endtask
  // tck stands low between frames, tdi inverted
  task automatic park;
    @(negedge i_clk);
    o_tck = 1'b0;
    o_tdi = ~o_tdi;
    repeat (4) @(negedge i_clk);
  endtask
  task automatic to_idle;
    logic d;
    repeat (10) bit_io(1'b1, 1'b1, d);
    bit_io(1'b0, 1'b1, d);
    park();
  endtask
  // from idle: capture, shift n bits lsb first, update, back to idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
    output logic [31:0] dout);
    logic d;
    dout = '0;
    bit_io(1'b1, 1'b0, d);
    if (ir) bit_io(1'b1, 1'b0, d);
    bit_io(1'b0, 1'b0, d);
    bit_io(1'b0, 1'b0, d);
    for (int i = 0; i < n; i++) bit_io(i == n - 1, din[i], dout[i]);
    bit_io(1'b1, 1'b0, d);
    bit_io(1'b0, 1'b0, d);
    park();
  endtask
endmodule
`default_nettype wire

// ===== bench/boundary_scan_tap_test.sv
`timescale 1ns/1ns
`default_nettype none
module boundary_scan_tap_test;
  localparam logic [31:0] ID = 32'h1234_5670; // arbitrary value
  logic i_clk, i_srst, tms_fl, tdi_fl, trst_n, trst_fl;
  logic [3:0] pin_in, core_out, bd_out, bd_oe, bd_in;
  wire tck, tms, tdi, tdo, tdo_oe, scan_mode, test_reset;
  wire [3:0] core_in, pin_out, pin_oe, pin_bd_out, pin_bd_oe, core_bd_in;
  logic [31:0] rd;
  int err_count, n_tests, cycles;
  // a released tdo line reads inverted, so a missing enable corrupts the data
  wire tdo_line = tdo_oe ? tdo : ~tdo;
  tap_tester tester (.i_clk(i_clk), .i_tdo(tdo_line), .o_tck(tck), .o_tms(tms), .o_tdi(tdi));
  boundary_scan_tap #(.ID_CODE(ID)) dut (.i_clk(i_clk), .i_srst(i_srst), .i_tck(tck),
    .i_tms(tms), .i_tms_float(tms_fl), .i_tdi(tdi), .i_tdi_float(tdi_fl),
    .i_trst_n(trst_n), .i_trst_float(trst_fl), .o_tdo(tdo), .o_tdo_oe(tdo_oe),
    .i_pin_in(pin_in), .o_core_in(core_in), .i_core_out(core_out), .o_pin_out(pin_out),
    .o_pin_out_oe(pin_oe), .i_core_bd_out(bd_out), .i_core_bd_oe(bd_oe),
    .i_pin_bd_in(bd_in), .o_pin_bd_out(pin_bd_out), .o_pin_bd_oe(pin_bd_oe),
    .o_core_bd_in(core_bd_in), .o_scan_mode(scan_mode), .o_test_reset(test_reset));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("tests %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic t_reset;
    chk({test_reset, pin_out}, {1'b1, core_out});
    tester.to_idle();
    tester.scan(1'b0, 32, 32'h0, rd);
    chk(rd, {ID[31:1], 1'b1});
    chk(tdo_oe, 1'b0);
    chk({core_in, core_bd_in}, {pin_in, bd_in});
    $display("done reset");
  endtask
  task automatic t_bypass;
    logic [3:0] ops [4] = '{4'hF, 4'h7, 4'h5, 4'hA};
    foreach (ops[k]) begin
      tester.scan(1'b1, 4, {28'h0, ops[k]}, rd);
      chk(rd[3:0], 4'h1);
      tdi_fl = ops[k] == 4'hA;
      tester.scan(1'b0, 8, 32'hB4, rd);
      chk(rd[7:0], tdi_fl ? 8'hFE : 8'h68);
      tdi_fl = 1'b0;
      chk(scan_mode, ops[k] == 4'h7);
      chk({pin_oe, pin_bd_oe} == 8'h0, ops[k] == 4'h5);
    end
    $display("done bypass");
  endtask
  task automatic t_sample;
    tester.scan(1'b1, 4, 32'h4, rd);
    tester.scan(1'b0, 12, 32'h5C9, rd);
    chk(rd[11:0], {bd_in, core_out, pin_in});
    chk(pin_out, core_out);
    tester.scan(1'b1, 4, 32'h0, rd);
    chk({pin_out, pin_oe, pin_bd_out, pin_bd_oe}, {12'hCF5, bd_oe});
    $display("done sample");
  endtask
  task automatic t_trst;
    trst_n = 1'b0;
    trst_fl = 1'b1;
    repeat (6) @(negedge i_clk);
    chk(test_reset, 1'b0);
    trst_fl = 1'b0;
    repeat (6) @(negedge i_clk);
    chk({test_reset, pin_out}, {1'b1, core_out});
    trst_n = 1'b1;
    tester.to_idle();
    tester.scan(1'b0, 32, 32'h0, rd);
    chk(rd, {ID[31:1], 1'b1});
    $display("done trst");
  endtask
  task automatic t_tms;
    tester.scan(1'b1, 4, 32'h0, rd);
    chk(test_reset, 1'b0);
    tms_fl = 1'b1;
    repeat (10) tester.bit_io(1'b0, 1'b0, rd[0]);
    tester.park();
    chk({test_reset, pin_out}, {1'b1, core_out});
    tms_fl = 1'b0;
    $display("done tms");
  endtask
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  initial begin
    {i_srst, tms_fl, tdi_fl, trst_n, trst_fl} = 5'b10010;
    {pin_in, core_out, bd_out, bd_oe, bd_in} = 20'h6_A2C3;
    repeat (5) @(negedge i_clk);
    i_srst = 1'b0;
    repeat (3) @(negedge i_clk);
    t_reset();
    t_bypass();
    t_sample();
    t_trst();
    t_tms();
    close_out();
  end
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 10000) begin
      err_count++;
      close_out();
    end
  end
endmodule
`default_nettype wire
